/* File: rtl/adr_result_regs.sv */
// adr_result_regs: result, comparator, delay and amplifier registers on ahb-lite
// assumes converter ready strobes are one-cycle pulses synchronous to clk_i
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// R1 - result registers keep newest conversion per channel
// R2 - result registers are read-only
// R3 - results read singly or linked, per increment field
// R4 - snapshot results when a read begins
// R5 - new result during read never corrupts word
// R6 - joined mode updates both results together
// R7 - 24-bit result codes, reset to zero
// R8 - offset and scale correction when enabled
// R9 - results presented as 16, 24 or 32 bits
// R10 - width codes: sign-extend, pad, 24, rounded 16
// R11 - joined single ready pulse, else per channel
// R12 - comparator snapshot captured every clock; a host write to it loads hwdata_i[7:0] for that cycle instead
// R13 - comparator bits: channel 1 high, channel 0 low
// R14 - comparator bits 23..8 read zero
// R15 - comparator resets to zero-volt pattern
// R16 - host should not write comparator snapshot
// R17 - delay write restarts active channels
// R18 - 12-bit delay in modulator clock periods
// R19 - delay upper bits read zero, resets zero
// R20 - 3-bit amplifier code per channel
// R21 - amplifier code decode, reserved codes unity
// R22 - unimplemented bits ignore writes, read zero
module adr_result_regs
    import adr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // converter side
    input  wire logic [23:0] ch0_code_i,
    input  wire logic        ch0_ready_i,
    input  wire logic [23:0] ch1_code_i,
    input  wire logic        ch1_ready_i,
    input  wire adr_cal_type cal_ch0_i,
    input  wire adr_cal_type cal_ch1_i,
    input  wire logic [7:0]  comparator_bits_i,
    // front-end control
    output logic             conversion_ready_n_o,
    output logic             restart_o,
    output logic      [11:0] channel_delay_o,
    output logic      [2:0]  gain_exp_ch0_o,
    output logic      [2:0]  gain_exp_ch1_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] adr_correct(input logic [23:0] code,
                                                input adr_cal_type cal,
                                                input logic off_on,
                                                input logic scale_on);
        logic signed [24:0] sum;
        logic signed [48:0] prod;
        logic        [24:0] res;
        sum  = $signed({code[23], code});
        if (off_on) begin
            sum = sum + $signed({cal.offset[23], cal.offset});
        end
        prod = sum * $signed(cal.scale);
        res  = scale_on ? 25'(sum) + prod[47:SCALE_FRAC] : 25'(sum);
        return res[23:0];
    endfunction

    function automatic logic [31:0] adr_format(input logic [23:0] code,
                                               input logic [1:0] width);
        logic [16:0] rnd;
        logic [15:0] sat;
        rnd = {code[23], code[23:8]} + {16'h0000, code[7]};
        sat = (!code[23] && rnd[15]) ? 16'h7fff : rnd[15:0];
        unique case (width) // [R10]
            WIDTH_32_SIGN:  return {{8{code[23]}}, code};
            WIDTH_32_PAD:   return {code, 8'h00};
            WIDTH_24:       return {8'h00, code};
            WIDTH_16_ROUND: return {16'h0000, sat};
        endcase
    endfunction

    function automatic logic [2:0] adr_gain_exp(input logic [2:0] code);
        return (code > GAIN_CODE_MAX) ? GAIN_EXP_UNITY : code;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adr_ctrl_type ctrl_r;
    logic [23:0]  result_live0_r;
    logic [23:0]  result_live1_r;
    logic [23:0]  stage0_r;
    logic [23:0]  stage1_r;
    logic         pend0_r;
    logic         pend1_r;
    logic [7:0]   comp_r;
    logic [11:0]  delay_r;
    logic [5:0]   gain_r;
    logic         hold_r;
    logic [23:0]  held1_r;
    logic         wr_pend_r;
    logic [4:0]   wr_idx_r;
    logic [31:0]  rd_data_r;
    logic         ready_n_r;
    logic         restart_r;
    logic [2:0]   gexp0_r;
    logic [2:0]   gexp1_r;

    logic [23:0]  corr0;
    logic [23:0]  corr1;
    logic         commit;
    logic         addr_ok;
    logic         rd_go;
    logic         wr_go;
    logic [4:0]   idx;
    logic [31:0]  rd_data_nxt;
    logic         wr_comp;

    assign corr0   = adr_correct(ch0_code_i, cal_ch0_i, ctrl_r.offset_correct_on,
                                 ctrl_r.scale_correct_on);      // [R8]
    assign corr1   = adr_correct(ch1_code_i, cal_ch1_i, ctrl_r.offset_correct_on,
                                 ctrl_r.scale_correct_on);      // [R8]
    assign commit  = ctrl_r.ready_pulse_join && (pend0_r || ch0_ready_i)
                     && (pend1_r || ch1_ready_i);               // [R6]
    assign idx     = haddr_i[6:2];
    assign addr_ok = (haddr_i[31:7] == 25'h0000000);
    assign rd_go   = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    assign wr_go   = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    assign wr_comp = wr_pend_r && (wr_idx_r == IDX_COMPARATOR);

    // ------------------------------------------------------------
    // conversion results
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_live0_r <= 24'h00_0000;
            result_live1_r <= 24'h00_0000;
            stage0_r       <= 24'h00_0000;
            stage1_r       <= 24'h00_0000;
            pend0_r        <= 1'b0;
            pend1_r        <= 1'b0;
        end else if (ctrl_r.ready_pulse_join) begin
            if (ch0_ready_i) begin
                stage0_r <= corr0;
            end
            if (ch1_ready_i) begin
                stage1_r <= corr1;
            end
            if (commit) begin
                // both channels land together on the lagging strobe
                result_live0_r <= ch0_ready_i ? corr0 : stage0_r;   // [R6] [R1]
                result_live1_r <= ch1_ready_i ? corr1 : stage1_r;   // [R6] [R1]
                pend0_r        <= 1'b0;
                pend1_r        <= 1'b0;
            end else begin
                pend0_r <= pend0_r || ch0_ready_i;
                pend1_r <= pend1_r || ch1_ready_i;
            end
        end else begin
            pend0_r <= 1'b0;
            pend1_r <= 1'b0;
            if (ch0_ready_i) begin
                result_live0_r <= corr0;                            // [R1] [R7]
            end
            if (ch1_ready_i) begin
                result_live1_r <= corr1;                            // [R1] [R7]
            end
        end
    end

    // ------------------------------------------------------------
    // data-ready pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_n_r <= 1'b1;
        end else if (ctrl_r.ready_pulse_join) begin
            ready_n_r <= !commit;                                   // [R11]
        end else begin
            ready_n_r <= !(ch0_ready_i || ch1_ready_i);             // [R11]
        end
    end

    // ------------------------------------------------------------
    // comparator snapshot
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_r <= COMP_RESET;                                   // [R15]
        end else if (wr_comp) begin
            comp_r <= hwdata_i[7:0];                                // [R22]
        end else begin
            comp_r <= comparator_bits_i;                            // [R12] [R13]
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r    <= CTRL_RESET;
            delay_r   <= DELAY_RESET;                               // [R19]
            gain_r    <= GAIN_RESET;
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_pend_r && (wr_idx_r == IDX_DELAY);      // [R17]
            if (wr_pend_r) begin
                unique case (wr_idx_r)
                    IDX_DELAY:       delay_r <= hwdata_i[11:0];     // [R18] [R22]
                    IDX_AMPLIFIER:   gain_r  <= hwdata_i[5:0];      // [R20] [R22]
                    IDX_RESULT_CTRL: ctrl_r  <= adr_ctrl_type'(hwdata_i[7:0] & 8'hf7);
                    default:         ;                              // [R2]
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gexp0_r <= GAIN_EXP_UNITY;
            gexp1_r <= GAIN_EXP_UNITY;
        end else begin
            gexp0_r <= adr_gain_exp(gain_r[2:0]);                   // [R21]
            gexp1_r <= adr_gain_exp(gain_r[5:3]);                   // [R21]
        end
    end

    // ------------------------------------------------------------
    // bus address and data phases
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 5'h00;
        end else begin
            wr_pend_r <= wr_go && addr_ok;
            wr_idx_r  <= idx;
        end
    end

    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        unique case (idx)
            IDX_RESULT_CH0:  rd_data_nxt = adr_format(result_live0_r,
                                                      ctrl_r.result_width);   // [R9] [R4]
            IDX_RESULT_CH1:  rd_data_nxt = adr_format(hold_r ? held1_r : result_live1_r,
                                                      ctrl_r.result_width);   // [R3] [R5]
            IDX_COMPARATOR:  rd_data_nxt = {24'h00_0000, comp_r};             // [R14]
            IDX_DELAY:       rd_data_nxt = {20'h0_0000, delay_r};             // [R19]
            IDX_AMPLIFIER:   rd_data_nxt = {26'h000_0000, gain_r};            // [R20]
            IDX_RESULT_CTRL: rd_data_nxt = {24'h00_0000, ctrl_r};
            default:         rd_data_nxt = 32'h0000_0000;                     // [R22]
        endcase
        if (!addr_ok) begin
            rd_data_nxt = 32'h0000_0000;
        end
    end

    // linked read: channel 1 frozen when channel 0 is read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_r    <= 1'b0;
            held1_r   <= 24'h00_0000;
            rd_data_r <= 32'h0000_0000;
        end else if (rd_go) begin
            rd_data_r <= rd_data_nxt;                               // [R4] [R5]
            if (addr_ok && idx == IDX_RESULT_CH0) begin
                hold_r  <= (ctrl_r.read_increment != READ_INC_SINGLE);  // [R3]
                held1_r <= result_live1_r;                          // [R4]
            end else if (addr_ok && idx == IDX_RESULT_CH1) begin
                hold_r  <= 1'b0;
            end
        end
    end

    assign hrdata_o             = rd_data_r;
    assign hreadyout_o          = 1'b1;
    assign hresp_o              = 1'b0;
    assign conversion_ready_n_o = ready_n_r;
    assign restart_o            = restart_r;
    assign channel_delay_o      = delay_r;
    assign gain_exp_ch0_o       = gexp0_r;
    assign gain_exp_ch1_o       = gexp1_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    result_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_r.ready_pulse_join && ch0_ready_i |=> result_live0_r == $past(corr0)) // [R1]
        else $error("channel 0 result not updated");

    result_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pend_r && !ch0_ready_i && !ch1_ready_i && !pend0_r && !pend1_r
        |=> $stable(result_live0_r) && $stable(result_live1_r)) // [R2]
        else $error("result changed by write");

    link_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && addr_ok && idx == IDX_RESULT_CH0 && ctrl_r.read_increment != 2'h0
        |=> hold_r && held1_r == $past(result_live1_r)) // [R3]
        else $error("linked read snapshot missing");

    read_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && addr_ok && idx == IDX_DELAY && !wr_pend_r
        |=> hrdata_o == {20'h0_0000, $past(delay_r)} && hrdata_o[31:12] == 20'h0_0000) // [R19]
        else $error("delay readback wrong");

    join_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_r.ready_pulse_join && ch0_ready_i && !pend1_r && !ch1_ready_i
        |=> $stable(result_live0_r) ##0 conversion_ready_n_o) // [R6]
        else $error("joined mode updated early");

    ready_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_r.ready_pulse_join && ch1_ready_i |=> !conversion_ready_n_o) // [R11]
        else $error("ready pulse missing");

    comp_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_comp |=> comp_r == $past(comparator_bits_i)) // [R12]
        else $error("comparator snapshot stale");

    delay_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pend_r && wr_idx_r == IDX_DELAY |=> restart_o ##1 !restart_o
        || $past(wr_pend_r)) // [R17]
        else $error("restart pulse wrong");

    gain_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        gain_r[2:0] > 3'h5 |=> gain_exp_ch0_o == 3'h0) // [R21]
        else $error("reserved gain not unity");

    round_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && addr_ok && idx == IDX_RESULT_CH0 && ctrl_r.result_width == 2'h0
        |=> hrdata_o[31:16] == 16'h0000) // [R10]
        else $error("16-bit result upper bits set");

    // readback and pulse checks
    comp_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && addr_ok && idx == IDX_COMPARATOR
        |=> hrdata_o[31:8] == '0) // [R14]
        else $error("comparator high bits set");

    gain_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && addr_ok && idx == IDX_AMPLIFIER
        |=> hrdata_o[31:6] == '0) // [R20]
        else $error("gain high bits set");

    join_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        commit
        |=> !conversion_ready_n_o) // [R11]
        else $error("joined ready pulse missing");

    unmapped_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_go && !addr_ok
        |=> hrdata_o == '0) // [R22]
        else $error("unmapped read not zero");

    restart_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart_o
        |-> $past(wr_pend_r) && $past(wr_idx_r) == IDX_DELAY) // [R17]
        else $error("restart without delay write");

endmodule

/* File: common/adr_pkg.sv */
// adr_pkg: constants and types of the converter result and front-end register bank
// assumes a 32-bit ahb-lite slave port, byte address = 4 * register index
package adr_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_RESULT_CH0   = 5'h00;
    localparam logic [4:0] IDX_RESULT_CH1   = 5'h01;
    localparam logic [4:0] IDX_COMPARATOR   = 5'h08;
    localparam logic [4:0] IDX_DELAY        = 5'h0a;
    localparam logic [4:0] IDX_AMPLIFIER    = 5'h0b;
    localparam logic [4:0] IDX_RESULT_CTRL  = 5'h0c;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         CODE_W           = 24;
    localparam int         DELAY_W          = 12;
    localparam int         GAIN_W           = 3;
    localparam int         COMP_W           = 8;
    localparam logic [7:0] COMP_RESET       = 8'h33;
    localparam logic [11:0] DELAY_RESET     = 12'h000;
    localparam logic [5:0] GAIN_RESET       = 6'h00;
    localparam logic [2:0] GAIN_CODE_MAX    = 3'h5;
    localparam logic [2:0] GAIN_EXP_UNITY   = 3'h0;

    // result width select
    localparam logic [1:0] WIDTH_32_SIGN    = 2'h3;
    localparam logic [1:0] WIDTH_32_PAD     = 2'h2;
    localparam logic [1:0] WIDTH_24         = 2'h1;
    localparam logic [1:0] WIDTH_16_ROUND   = 2'h0;

    // read increment select
    localparam logic [1:0] READ_INC_SINGLE  = 2'h0;
    localparam logic [1:0] READ_INC_RESET   = 2'h2;

    // result control register bit positions
    localparam int         CTRL_WIDTH_LSB   = 0;
    localparam int         CTRL_JOIN_BIT    = 2;
    localparam int         CTRL_INC_LSB     = 4;
    localparam int         CTRL_OFFSET_BIT  = 6;
    localparam int         CTRL_SCALE_BIT   = 7;

    // scale correction fraction bits
    localparam int         SCALE_FRAC       = 23;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       scale_correct_on;
        logic       offset_correct_on;
        logic [1:0] read_increment;
        logic       spare_zero;
        logic       ready_pulse_join;
        logic [1:0] result_width;
    } adr_ctrl_type;

    localparam adr_ctrl_type CTRL_RESET = '{
        scale_correct_on:  1'b0,
        offset_correct_on: 1'b0,
        read_increment:    READ_INC_RESET,
        spare_zero:        1'b0,
        ready_pulse_join:  1'b0,
        result_width:      WIDTH_24
    };

    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] scale;
    } adr_cal_type;

endpackage

/* File: sim/adr_conv_model.sv */
// adr_conv_model: converter front end feeding the result register bank
// assumes calls to its tasks are made just after a rising edge of clk_i
`timescale 1ns/1ps

module adr_conv_model
    import adr_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // conversion results
    output logic      [23:0] ch0_code_o,
    output logic             ch0_ready_o,
    output logic      [23:0] ch1_code_o,
    output logic             ch1_ready_o,
    // live modulator comparators
    output logic      [7:0]  comparator_bits_o
);

    // ------------------------------------------------------------
    // idle state: zero-volt comparator pattern, no strobes
    // ------------------------------------------------------------
    initial begin
        ch0_code_o        = 24'h00_0000;
        ch1_code_o        = 24'h00_0000;
        ch0_ready_o       = 1'b0;
        ch1_ready_o       = 1'b0;
        comparator_bits_o = 8'h33;
    end

    // ------------------------------------------------------------
    // one-cycle strobe; code is not held once the strobe drops
    // ------------------------------------------------------------
    task automatic fire(input logic go0, input logic go1,
                        input logic [23:0] c0, input logic [23:0] c1);
        ch0_code_o  <= c0;
        ch1_code_o  <= c1;
        ch0_ready_o <= go0;
        ch1_ready_o <= go1;
        @(posedge clk_i);
        ch0_ready_o <= 1'b0;
        ch1_ready_o <= 1'b0;
        ch0_code_o  <= ~c0;
        ch1_code_o  <= ~c1;
        @(posedge clk_i);
    endtask

    task automatic set_comp(input logic [7:0] v);
        comparator_bits_o <= v;
        @(posedge clk_i);
    endtask

endmodule

/* File: sim/tb.sv */
// tb: register bank bench driving ahb-lite reads and writes
// assumes zero-wait slave; the converter model supplies codes and strobes
`timescale 1ns/1ps

module tb
    import adr_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              clk_i, rst_i, hsel, hwrite, hready, hresp;
    logic        [1:0] htrans;
    logic       [31:0] haddr, hwdata, hrdata, rdata;
    logic       [23:0] c0, c1;
    logic              r0, r1, rdy_n, restart;
    logic        [7:0] comp;
    logic       [11:0] delay;
    logic        [2:0] gexp0, gexp1, g;
    adr_cal_type       cal;
    int                err_total, check_count, rdy_cnt, rst_cnt, cyc, n;
    logic       [31:0] wt [3][3] = '{'{32'h0000_0003, 32'hFF81_2345, 32'h007F_FF80},
                                     '{32'h0000_0002, 32'h8123_4500, 32'h7FFF_8000},
                                     '{32'h0000_0000, 32'h0000_8123, 32'h0000_7FFF}};
    logic       [31:0] ct [4][2] = '{'{32'h0000_0041, 32'h0000_0110},
                                     '{32'h0000_00C1, 32'h0000_0198},
                                     '{32'h0000_0081, 32'h0000_0180},
                                     '{32'h0000_0001, 32'h0000_0100}};

    adr_conv_model conv_u (.clk_i(clk_i), .ch0_code_o(c0), .ch0_ready_o(r0),
                           .ch1_code_o(c1), .ch1_ready_o(r1), .comparator_bits_o(comp));

    adr_result_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .ch0_code_i(c0), .ch0_ready_i(r0), .ch1_code_i(c1), .ch1_ready_i(r1),
        .cal_ch0_i(cal), .cal_ch1_i(cal), .comparator_bits_i(comp),
        .conversion_ready_n_o(rdy_n), .restart_o(restart), .channel_delay_o(delay),
        .gain_exp_ch0_o(gexp0), .gain_exp_ch1_o(gexp1));

    // ------------------------------------------------------------
    // clock, pulse counters and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (!rst_i && rdy_n === 1'b0) rdy_cnt++;
        if (!rst_i && restart === 1'b1) rst_cnt++;
        if (cyc == 6000) begin
            err_total++;
            close_out;
        end
    end

    // ------------------------------------------------------------
    // bus access and comparison
    // ------------------------------------------------------------
    function automatic logic [31:0] addr(input logic [4:0] idx);
        return {25'h000_0000, idx, 2'b00};
    endfunction

    function automatic logic [2:0] gx(input logic [2:0] k);
        return (k > 3'h5) ? 3'h0 : k;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rdata = hrdata;
        // write lands at the end of its data phase; the gain exponent outputs follow one cycle later
        if (wr) @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [31:0] exp, input string nm);
        bus(1'b0, addr(idx), 32'h0000_0000);
        check(nm, rdata, exp);
    endtask

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        bus(1'b1, addr(idx), d);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        cal = '{offset: 24'h00_0010, scale: 24'h40_0000};
        err_total = 0;
        check_count = 0;
        rdy_cnt = 0;
        rst_cnt = 0;
        cyc = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("outs", {11'h000, hresp, rdy_n, restart, delay, gexp1, gexp0},
              32'h0008_0000);
        rd(IDX_RESULT_CH0, 32'h0000_0000, "ch0 reset");
        rd(IDX_RESULT_CH1, 32'h0000_0000, "ch1 reset");
        rd(IDX_COMPARATOR, 32'h0000_0033, "comp reset");
        rd(IDX_DELAY, 32'h0000_0000, "delay reset");
        rd(IDX_AMPLIFIER, 32'h0000_0000, "gain reset");
        rd(IDX_RESULT_CTRL, 32'h0000_0021, "ctrl reset");
        // comparator only read, never written by the host
        conv_u.set_comp(8'hA5);
        rd(IDX_COMPARATOR, 32'h0000_00A5, "comp a5");
        conv_u.set_comp(8'h5A);
        rd(IDX_COMPARATOR, 32'h0000_005A, "comp 5a");
        wr(5'h02, 32'hFFFF_FFFF);
        rd(5'h02, 32'h0000_0000, "unmapped");
        n = rst_cnt;
        wr(IDX_DELAY, 32'hFFFF_FABC);
        rd(IDX_DELAY, 32'h0000_0ABC, "delay");
        check("delay out", 32'(delay), 32'h0000_0ABC);
        check("restart 1", 32'(rst_cnt - n), 32'h0000_0001);
        wr(IDX_DELAY, 32'h0000_0ABC);
        rd(IDX_DELAY, 32'h0000_0ABC, "delay again");
        check("restart 2", 32'(rst_cnt - n), 32'h0000_0002);
        for (int k = 0; k < 8; k++) begin
            g = k[2:0];
            wr(IDX_AMPLIFIER, 32'hFFFF_FFC0 | {26'h000_0000, g, ~g});
            rd(IDX_AMPLIFIER, {26'h000_0000, g, ~g}, "gain");
            check("gexp0", 32'(gexp0), 32'(gx(~g)));
            check("gexp1", 32'(gexp1), 32'(gx(g)));
        end
        wr(IDX_RESULT_CTRL, 32'h0000_0001);
        n = rdy_cnt;
        conv_u.fire(1'b1, 1'b0, 24'h81_2345, 24'h00_0000);
        conv_u.fire(1'b0, 1'b1, 24'h00_0000, 24'h7F_FF80);
        rd(IDX_RESULT_CH0, 32'h0081_2345, "ch0 code");
        rd(IDX_RESULT_CH1, 32'h007F_FF80, "ch1 code");
        check("pulses apart", 32'(rdy_cnt - n), 32'h0000_0002);
        wr(IDX_RESULT_CH0, 32'hFFFF_FFFF);
        wr(IDX_RESULT_CH1, 32'h0000_0000);
        rd(IDX_RESULT_CH0, 32'h0081_2345, "ch0 ro");
        rd(IDX_RESULT_CH1, 32'h007F_FF80, "ch1 ro");
        bus(1'b0, 32'h0000_0080, 32'h0000_0000);
        check("high addr", rdata, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_RESULT_CTRL, wt[k][0]);
            rd(IDX_RESULT_CH0, wt[k][1], "ch0 width");
            rd(IDX_RESULT_CH1, wt[k][2], "ch1 width");
        end
        wr(IDX_RESULT_CTRL, 32'h0000_0011);
        conv_u.fire(1'b0, 1'b1, 24'h00_0000, 24'h00_0AAA);
        rd(IDX_RESULT_CH0, 32'h0081_2345, "linked ch0");
        conv_u.fire(1'b0, 1'b1, 24'h00_0000, 24'h00_0BBB);
        rd(IDX_RESULT_CH1, 32'h0000_0AAA, "frozen ch1");
        rd(IDX_RESULT_CH1, 32'h0000_0BBB, "newest ch1");
        wr(IDX_RESULT_CTRL, 32'h0000_0005);
        n = rdy_cnt;
        conv_u.fire(1'b1, 1'b0, 24'h00_0123, 24'h00_0000);
        rd(IDX_RESULT_CH0, 32'h0081_2345, "half join");
        check("no pulse", 32'(rdy_cnt - n), 32'h0000_0000);
        conv_u.fire(1'b0, 1'b1, 24'h00_0000, 24'h00_0456);
        rd(IDX_RESULT_CH0, 32'h0000_0123, "join ch0");
        rd(IDX_RESULT_CH1, 32'h0000_0456, "join ch1");
        check("one pulse", 32'(rdy_cnt - n), 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_RESULT_CTRL, ct[k][0]);
            conv_u.fire(1'b1, 1'b0, 24'h00_0100, 24'h00_0000);
            rd(IDX_RESULT_CH0, ct[k][1], "corrected");
        end
        close_out;
    end

endmodule
